// ### hw/ecl_pkg.sv
// Constants for the power-up configuration loader.
// Assumes a byte-wide configuration memory read port on the same clock.
package ecl_pkg;
  // Configuration memory layout
  localparam logic [7:0]  EE_SIG_ADDR   = 8'h00;
  localparam logic [7:0]  EE_LOAD_BASE  = 8'h04;
  localparam logic [7:0]  SIGNATURE     = 8'hA5;
  localparam int          LOAD_BYTES    = 22;
  localparam logic [4:0]  STEP_LAST     = 5'd21;
  localparam logic [4:0]  STEP_POLL_FS  = 5'd16;
  localparam logic [4:0]  STEP_POLL_HS  = 5'd17;
  localparam logic [4:0]  STEP_POLL_SS  = 5'd18;
  localparam logic [4:0]  STEP_BURST    = 5'd19;
  localparam logic [4:0]  STEP_PWR_U2   = 5'd20;
  localparam logic [4:0]  STEP_PWR_U3   = 5'd21;

  // Built-in defaults when no memory is attached
  localparam logic [7:0]  DEF_POLL_FS   = 8'h01;
  localparam logic [7:0]  DEF_POLL_HS   = 8'h04;
  localparam logic [7:0]  DEF_POLL_SS   = 8'h06;
  localparam logic [7:0]  DEF_BURST     = 8'h07;
  localparam logic [31:0] DEF_FLAG0     = 32'h0000_0008;
  localparam logic [31:0] DEF_FLAG1     = 32'h1620_6935;
  localparam logic [31:0] DEF_FLAG2     = 32'h0000_0900;
  localparam logic [31:0] DEF_FLAG3     = 32'h0000_0005;
  localparam logic [7:0]  DEF_PWR_U2    = 8'hFA;
  localparam logic [7:0]  DEF_PWR_U3    = 8'h70;

  // Flag word 1 fields
  localparam int F1_DMID_MSB = 29;
  localparam int F1_DMID_LSB = 24;
  localparam int F1_DHI_MSB  = 21;
  localparam int F1_DHI_LSB  = 16;
  localparam int F1_FULL_MSB = 14;
  localparam int F1_FULL_LSB = 8;
  localparam int F1_LOW_MSB  = 6;
  localparam int F1_LOW_LSB  = 0;
  localparam logic [31:0] F1_USED = 32'h3F3F_7F7F;
  // Flag word 2 fields
  localparam int F2_LOS_MSB  = 12;
  localparam int F2_LOS_LSB  = 8;
  localparam int F2_TERM_MSB = 4;
  localparam int F2_TERM_LSB = 0;
  localparam logic [31:0] F2_USED = 32'h0000_1F1F;
  // Flag word 3 fields
  localparam int F3_RNG_MSB  = 2;
  localparam int F3_RNG_LSB  = 1;
  localparam int F3_ON_BIT   = 0;
  localparam logic [31:0] F3_USED = 32'h0000_0007;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FLAG0   = 8'h08;
  localparam logic [7:0] OFS_FLAG1   = 8'h0C;
  localparam logic [7:0] OFS_FLAG2   = 8'h10;
  localparam logic [7:0] OFS_FLAG3   = 8'h14;
  localparam logic [7:0] OFS_PHY_A   = 8'h18;
  localparam logic [7:0] OFS_PHY_B   = 8'h1C;
  localparam logic [7:0] OFS_PLL     = 8'h20;
  localparam logic [7:0] OFS_USB     = 8'h24;
  localparam logic [7:0] OFS_PWR     = 8'h28;
  localparam int         CTRL_RELOAD = 0;
  localparam int         ST_DONE     = 0;
  localparam int         ST_PRESENT  = 1;
  localparam int         ST_BUSY     = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ecl_pkg

// ### hw/ecl_fetch.sv
// One byte read from the configuration memory per start pulse.
// Assumes the memory port acknowledges with a one-cycle pulse, same clock.
`timescale 1ns/1ps
module ecl_fetch (
  input  wire logic       aclk,        // Clock
  input  wire logic       aresetn,     // Synchronous reset, low
  input  wire logic       start,       // Begin a read
  input  wire logic [7:0] addr,        // Byte address
  output logic            done,        // Read finished, pulse
  output logic [7:0]      data,        // Byte read
  output logic            ee_rd_req,   // Read request level
  output logic [7:0]      ee_rd_addr,  // Read address
  input  wire logic       ee_rd_ack,   // Data valid pulse
  input  wire logic [7:0] ee_rd_data   // Read data
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_rd_req  <= 1'b0;
      ee_rd_addr <= 8'h00;
    end else if (start) begin
      ee_rd_req  <= 1'b1;
      ee_rd_addr <= addr;
    end else if (ee_rd_ack) begin
      ee_rd_req  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      data <= 8'h00;
    end else begin
      done <= ee_rd_req && ee_rd_ack;
      if (ee_rd_req && ee_rd_ack) begin
        data <= ee_rd_data;
      end
    end
  end
endmodule : ecl_fetch

// ### hw/ecl_unpack.sv
// Spreads flag words 1 to 3 into PHY and PLL fields on an apply pulse.
// Assumes the flag words are stable in the apply cycle.
`timescale 1ns/1ps
module ecl_unpack (
  input  wire logic        aclk,                      // Clock
  input  wire logic        aresetn,                   // Sync reset, low
  input  wire logic        apply,                     // Take new words
  input  wire logic [31:0] flag1,                     // Flag word 1
  input  wire logic [31:0] flag2,                     // Flag word 2
  input  wire logic [31:0] flag3,                     // Flag word 3
  output logic [5:0]       phy_deemph_mid_level,      // De-emphasis 3.5 dB
  output logic [5:0]       phy_deemph_high_level,     // De-emphasis 6 dB
  output logic [6:0]       phy_amp_full_swing,        // Full swing amplitude
  output logic [6:0]       phy_amp_low_swing,         // Low swing amplitude
  output logic [4:0]       phy_signal_loss_threshold, // Loss of signal level
  output logic [4:0]       phy_termination_trim,      // Termination offset
  output logic [1:0]       pll_spread_range,          // Spread range
  output logic             pll_spread_on              // Spread enable
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_deemph_mid_level      <= '0;
      phy_deemph_high_level     <= '0;
      phy_amp_full_swing        <= '0;
      phy_amp_low_swing         <= '0;
      phy_signal_loss_threshold <= '0;
      phy_termination_trim      <= '0;
      pll_spread_range          <= '0;
      pll_spread_on             <= 1'b0;
    end else if (apply) begin
      phy_deemph_mid_level  <=
        flag1[ecl_pkg::F1_DMID_MSB:ecl_pkg::F1_DMID_LSB];
      phy_deemph_high_level <=
        flag1[ecl_pkg::F1_DHI_MSB:ecl_pkg::F1_DHI_LSB];
      phy_amp_full_swing    <=
        flag1[ecl_pkg::F1_FULL_MSB:ecl_pkg::F1_FULL_LSB];
      phy_amp_low_swing     <=
        flag1[ecl_pkg::F1_LOW_MSB:ecl_pkg::F1_LOW_LSB];
      phy_signal_loss_threshold <=
        flag2[ecl_pkg::F2_LOS_MSB:ecl_pkg::F2_LOS_LSB];
      phy_termination_trim  <=
        flag2[ecl_pkg::F2_TERM_MSB:ecl_pkg::F2_TERM_LSB];
      pll_spread_range      <=
        flag3[ecl_pkg::F3_RNG_MSB:ecl_pkg::F3_RNG_LSB];
      pll_spread_on         <= flag3[ecl_pkg::F3_ON_BIT];
    end
  end
endmodule : ecl_unpack

// ### hw/ecl_loader.sv
// Power-up configuration loader with AXI4-Lite status and readback.
// Assumes a byte read port to the configuration memory on aclk.
//
// Overview of operation
// - Present only when address zero holds signature.
// - Bad signature: use built-in defaults instead.
// - Flag1 bits 29:24 set mid de-emphasis.
// - Flag1 bits 21:16 set high de-emphasis.
// - Flag1 bits 14:8 set full swing amplitude.
// - Flag1 bits 6:0 set low swing amplitude.
// - Flag2 bits 12:8 set loss threshold.
// - Flag2 bits 4:0 set termination trim.
// - Flag3 bits 2:1 set spread range.
// - Flag3 bit 0 sets spread enable.
// - Absent: polling intervals 01h, 04h, 06h.
// - Absent: bulk-out burst size 07h.
// - Absent: flag words take built-in defaults.
// - Absent: max power FAh, or 70h super-speed.
`timescale 1ns/1ps
module ecl_loader (
  input  wire logic        aclk,          // Clock, 250 MHz
  input  wire logic        aresetn,       // Sync reset, low
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [7:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  // Configuration memory port
  output logic             ee_rd_req,     // Read request
  output logic [7:0]       ee_rd_addr,    // Read address
  input  wire logic        ee_rd_ack,     // Read data valid pulse
  input  wire logic [7:0]  ee_rd_data,    // Read data
  // Device state
  input  wire logic        usb3_mode,     // Super-speed link active
  output logic             cfg_done,      // Load finished
  output logic             cfg_present,   // Memory found
  output logic [7:0]       poll_fs,       // Full-speed polling interval
  output logic [7:0]       poll_hs,       // High-speed polling interval
  output logic [7:0]       poll_ss,       // Super-speed polling interval
  output logic [7:0]       bulk_burst,    // Bulk-out max burst
  output logic [7:0]       max_power,     // Reported max power
  output logic [5:0]       phy_deemph_mid_level,      // De-emph 3.5 dB
  output logic [5:0]       phy_deemph_high_level,     // De-emph 6 dB
  output logic [6:0]       phy_amp_full_swing,        // Full swing
  output logic [6:0]       phy_amp_low_swing,         // Low swing
  output logic [4:0]       phy_signal_loss_threshold, // Phy_signal_loss_threshold
  output logic [4:0]       phy_termination_trim,      // Term offset
  output logic [1:0]       pll_spread_range,          // Spread range
  output logic             pll_spread_on              // Spread enable
);
  typedef enum logic [2:0] {
    ST_START, ST_SIG, ST_LREQ, ST_LWAIT, ST_APPLY, ST_IDLE
  } ecl_state_e;

  ecl_state_e  state_reg;
  logic [4:0]  step_reg;
  logic [31:0] flag_reg [4];
  logic [7:0]  pwr_u2_reg;
  logic [7:0]  pwr_u3_reg;
  logic        fetch_start;
  logic [7:0]  fetch_addr;
  logic        fetch_done;
  logic [7:0]  fetch_data;
  logic        apply;
  logic        reload;

  function automatic logic [7:0] load_addr(input logic [4:0] step);
    load_addr = ecl_pkg::EE_LOAD_BASE + {3'b000, step};
  endfunction : load_addr

  assign fetch_start = (state_reg == ST_START) || (state_reg == ST_LREQ);
  assign fetch_addr  = (state_reg == ST_START) ? ecl_pkg::EE_SIG_ADDR
                                               : load_addr(step_reg);
  assign apply       = (state_reg == ST_APPLY);

  ecl_fetch u_fetch (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (fetch_start),
    .addr       (fetch_addr),
    .done       (fetch_done),
    .data       (fetch_data),
    .ee_rd_req  (ee_rd_req),
    .ee_rd_addr (ee_rd_addr),
    .ee_rd_ack  (ee_rd_ack),
    .ee_rd_data (ee_rd_data)
  );

  // Load sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_START;
      step_reg  <= 5'd0;
    end else begin
      case (state_reg)
        ST_START: state_reg <= ST_SIG;
        ST_SIG: begin
          if (fetch_done) begin
            step_reg  <= 5'd0;
            state_reg <= (fetch_data == ecl_pkg::SIGNATURE) ? ST_LREQ
                                                            : ST_APPLY;
          end
        end
        ST_LREQ: state_reg <= ST_LWAIT;
        ST_LWAIT: begin
          if (fetch_done) begin
            step_reg  <= step_reg + 5'd1;
            state_reg <= (step_reg == ecl_pkg::STEP_LAST) ? ST_APPLY
                                                          : ST_LREQ;
          end
        end
        ST_APPLY: state_reg <= ST_IDLE;
        ST_IDLE:  if (reload) state_reg <= ST_START;
        default:  state_reg <= ST_START;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_present <= 1'b0;
      cfg_done    <= 1'b0;
    end else begin
      if (state_reg == ST_SIG && fetch_done) begin
        cfg_present <= (fetch_data == ecl_pkg::SIGNATURE);
      end
      if (state_reg == ST_START) begin
        cfg_done <= 1'b0;
      end else if (apply) begin
        cfg_done <= 1'b1;
      end
    end
  end

  // Loaded or default settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) flag_reg[i] <= 32'h0000_0000;
      poll_fs    <= 8'h00;
      poll_hs    <= 8'h00;
      poll_ss    <= 8'h00;
      bulk_burst <= 8'h00;
      pwr_u2_reg <= 8'h00;
      pwr_u3_reg <= 8'h00;
    end else if (state_reg == ST_SIG && fetch_done &&
                 fetch_data != ecl_pkg::SIGNATURE) begin
      flag_reg[0] <= ecl_pkg::DEF_FLAG0;
      flag_reg[1] <= ecl_pkg::DEF_FLAG1;
      flag_reg[2] <= ecl_pkg::DEF_FLAG2;
      flag_reg[3] <= ecl_pkg::DEF_FLAG3;
      poll_fs     <= ecl_pkg::DEF_POLL_FS;
      poll_hs     <= ecl_pkg::DEF_POLL_HS;
      poll_ss     <= ecl_pkg::DEF_POLL_SS;
      bulk_burst  <= ecl_pkg::DEF_BURST;
      pwr_u2_reg  <= ecl_pkg::DEF_PWR_U2;
      pwr_u3_reg  <= ecl_pkg::DEF_PWR_U3;
    end else if (state_reg == ST_LWAIT && fetch_done) begin
      case (step_reg)
        ecl_pkg::STEP_POLL_FS: poll_fs    <= fetch_data;
        ecl_pkg::STEP_POLL_HS: poll_hs    <= fetch_data;
        ecl_pkg::STEP_POLL_SS: poll_ss    <= fetch_data;
        ecl_pkg::STEP_BURST:   bulk_burst <= fetch_data;
        ecl_pkg::STEP_PWR_U2:  pwr_u2_reg <= fetch_data;
        ecl_pkg::STEP_PWR_U3:  pwr_u3_reg <= fetch_data;
        default: flag_reg[step_reg[3:2]][{step_reg[1:0], 3'b000} +: 8]
                   <= fetch_data; // Little-endian flag words
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_power <= 8'h00;
    end else begin
      max_power <= usb3_mode ? pwr_u3_reg : pwr_u2_reg;
    end
  end

  // Only field slices reach the PHY, reserved bits drop out
  ecl_unpack u_unpack (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .apply                     (apply),
    .flag1                     (flag_reg[1]),
    .flag2                     (flag_reg[2]),
    .flag3                     (flag_reg[3]),
    .phy_deemph_mid_level      (phy_deemph_mid_level),
    .phy_deemph_high_level     (phy_deemph_high_level),
    .phy_amp_full_swing        (phy_amp_full_swing),
    .phy_amp_low_swing         (phy_amp_low_swing),
    .phy_signal_loss_threshold (phy_signal_loss_threshold),
    .phy_termination_trim      (phy_termination_trim),
    .pll_spread_range          (pll_spread_range),
    .pll_spread_on             (pll_spread_on)
  );

  // PHY register images for readback
  logic [31:0] phy_param_reg_a;
  logic [31:0] phy_param_reg_b;
  logic [31:0] phy_pll_control_reg;
  assign phy_param_reg_a = {2'b00, phy_deemph_mid_level, 2'b00,
                            phy_deemph_high_level, 1'b0, phy_amp_full_swing,
                            1'b0, phy_amp_low_swing};
  assign phy_param_reg_b = {19'h0_0000, phy_signal_loss_threshold, 3'b000,
                            phy_termination_trim};
  assign phy_pll_control_reg = {29'h0000_0000, pll_spread_range,
                                pll_spread_on};

  // AXI4-Lite write path, address and data in either order
  logic       aw_got_reg;
  logic       w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] w_data_reg;
  logic       wr_fire;

  assign s_awready = !aw_got_reg && !s_bvalid;
  assign s_wready  = !w_got_reg && !s_bvalid;
  assign wr_fire   = aw_got_reg && w_got_reg && !s_bvalid;
  assign reload    = wr_fire && aw_addr_reg == ecl_pkg::OFS_CTRL &&
                     w_strb_reg[0] && w_data_reg[ecl_pkg::CTRL_RELOAD];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_strb_reg  <= 4'h0;
      w_data_reg  <= 32'h0000_0000;
      s_bvalid    <= 1'b0;
      s_bresp     <= ecl_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_reg  <= 1'b1;
        w_strb_reg <= s_wstrb;
        w_data_reg <= s_wdata;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        s_bvalid   <= 1'b1;
        s_bresp    <= (aw_addr_reg == ecl_pkg::OFS_CTRL)
                      ? ecl_pkg::RESP_OKAY : ecl_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= ecl_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= ecl_pkg::RESP_OKAY;
      case (s_araddr)
        ecl_pkg::OFS_CTRL:   s_rdata <= 32'h0000_0000;
        ecl_pkg::OFS_STATUS: s_rdata <= {29'h0000_0000,
                                         state_reg != ST_IDLE,
                                         cfg_present, cfg_done};
        ecl_pkg::OFS_FLAG0:  s_rdata <= flag_reg[0];
        ecl_pkg::OFS_FLAG1:  s_rdata <= flag_reg[1];
        ecl_pkg::OFS_FLAG2:  s_rdata <= flag_reg[2];
        ecl_pkg::OFS_FLAG3:  s_rdata <= flag_reg[3];
        ecl_pkg::OFS_PHY_A:  s_rdata <= phy_param_reg_a;
        ecl_pkg::OFS_PHY_B:  s_rdata <= phy_param_reg_b;
        ecl_pkg::OFS_PLL:    s_rdata <= phy_pll_control_reg;
        ecl_pkg::OFS_USB:    s_rdata <= {bulk_burst, poll_ss, poll_hs,
                                         poll_fs};
        ecl_pkg::OFS_PWR:    s_rdata <= {8'h00, pwr_u3_reg, pwr_u2_reg,
                                         max_power};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= ecl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sig_check;
    (state_reg == ST_SIG && fetch_done)
      |=> cfg_present == ($past(fetch_data) == ecl_pkg::SIGNATURE);
  endproperty
  a_sig_check: assert property (p_sig_check)
    else $error("presence does not follow signature byte");

  property p_absent_flags;
    (cfg_done && !cfg_present) |-> flag_reg[0] == ecl_pkg::DEF_FLAG0 &&
      flag_reg[2] == ecl_pkg::DEF_FLAG2 && flag_reg[3] == ecl_pkg::DEF_FLAG3;
  endproperty
  a_absent_flags: assert property (p_absent_flags)
    else $error("absent memory flag defaults wrong");

  property p_absent_nofetch;
    (state_reg == ST_SIG && fetch_done &&
     fetch_data != ecl_pkg::SIGNATURE) |=> ##[1:2] !ee_rd_req && cfg_done;
  endproperty
  a_absent_nofetch: assert property (p_absent_nofetch)
    else $error("absent memory still loaded");

  property p_deemph_mid;
    cfg_done |-> phy_deemph_mid_level ==
      flag_reg[1][ecl_pkg::F1_DMID_MSB:ecl_pkg::F1_DMID_LSB];
  endproperty
  a_deemph_mid: assert property (p_deemph_mid)
    else $error("mid de-emphasis mismatch");

  property p_deemph_high;
    cfg_done |-> phy_deemph_high_level ==
      flag_reg[1][ecl_pkg::F1_DHI_MSB:ecl_pkg::F1_DHI_LSB];
  endproperty
  a_deemph_high: assert property (p_deemph_high)
    else $error("high de-emphasis mismatch");

  property p_swing;
    cfg_done |-> phy_amp_full_swing ==
      flag_reg[1][ecl_pkg::F1_FULL_MSB:ecl_pkg::F1_FULL_LSB] &&
      phy_amp_low_swing ==
      flag_reg[1][ecl_pkg::F1_LOW_MSB:ecl_pkg::F1_LOW_LSB];
  endproperty
  a_swing: assert property (p_swing)
    else $error("swing amplitude mismatch");

  property p_phy_b;
    cfg_done |-> phy_param_reg_b ==
      (flag_reg[2] & ecl_pkg::F2_USED);
  endproperty
  a_phy_b: assert property (p_phy_b)
    else $error("loss threshold or trim mismatch");

  property p_pll;
    cfg_done |-> phy_pll_control_reg == (flag_reg[3] & ecl_pkg::F3_USED);
  endproperty
  a_pll: assert property (p_pll)
    else $error("spread fields mismatch");

  property p_reserved;
    cfg_done |-> phy_param_reg_a == (flag_reg[1] & ecl_pkg::F1_USED);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits reached a field");

  property p_absent_usb;
    (cfg_done && !cfg_present) |-> poll_fs == ecl_pkg::DEF_POLL_FS &&
      poll_hs == ecl_pkg::DEF_POLL_HS && poll_ss == ecl_pkg::DEF_POLL_SS;
  endproperty
  a_absent_usb: assert property (p_absent_usb)
    else $error("polling defaults wrong");

  property p_absent_burst;
    (cfg_done && !cfg_present) |-> bulk_burst == ecl_pkg::DEF_BURST;
  endproperty
  a_absent_burst: assert property (p_absent_burst)
    else $error("burst default wrong");

  property p_absent_pwr;
    (cfg_done && !cfg_present && $past(cfg_done)) |-> max_power ==
      ($past(usb3_mode) ? ecl_pkg::DEF_PWR_U3 : ecl_pkg::DEF_PWR_U2);
  endproperty
  a_absent_pwr: assert property (p_absent_pwr)
    else $error("max power default wrong");

  c_present: cover property (cfg_done && cfg_present);
  c_absent:  cover property (cfg_done && !cfg_present);
  c_reload:  cover property (reload);
  c_rd_err:  cover property (s_rvalid && s_rresp == ecl_pkg::RESP_SLVERR);
endmodule : ecl_loader

// ### test/ecl_eeprom_model.sv
// Configuration memory model behind the byte read port.
// Assumes the bench fills mem and sets the answer delay.
`timescale 1ns/1ps
module ecl_eeprom_model (
  input  wire logic       aclk,        // Clock
  input  wire logic       ee_rd_req,   // Read request
  input  wire logic [7:0] ee_rd_addr,  // Byte address
  input  wire logic [3:0] wait_cycles, // Answer delay
  output logic            ee_rd_ack,   // Data valid pulse
  output logic [7:0]      ee_rd_data   // Byte read
);
  logic [7:0] mem [0:31];
  logic [3:0] cnt = 4'h0;
  initial ee_rd_ack = 1'b0;
  initial ee_rd_data = 8'h00;
  always @(posedge aclk) begin
    ee_rd_ack <= 1'b0;
    ee_rd_data <= ~ee_rd_data; // Released: toggle
    cnt <= 4'h0;
    if (ee_rd_req && !ee_rd_ack && cnt != wait_cycles) cnt <= cnt + 4'h1;
    else if (ee_rd_req && !ee_rd_ack) begin
      ee_rd_ack <= 1'b1;
      ee_rd_data <= mem[ee_rd_addr[4:0]];
    end
  end
endmodule : ecl_eeprom_model

// ### test/ecl_loader_test.sv
// Bench for the loader: absent memory, bus errors, full load.
// Assumes ecl_eeprom_model on the memory port.
`timescale 1ns/1ps
module ecl_loader_test;
  logic aclk = 1'b0, aresetn = 1'b0, usb3_mode = 1'b0, s_awvalid = 1'b0;
  logic s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'hF, wcyc = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ee_rd_req;
  logic ee_rd_ack, cfg_done, cfg_present, pll_spread_on;
  logic [1:0] s_bresp, s_rresp, pll_spread_range;
  logic [31:0] s_rdata;
  logic [7:0] ee_rd_addr, ee_rd_data, poll_fs, poll_hs, poll_ss;
  logic [7:0] bulk_burst, max_power;
  logic [5:0] phy_deemph_mid_level, phy_deemph_high_level;
  logic [6:0] phy_amp_full_swing, phy_amp_low_swing;
  logic [4:0] phy_signal_loss_threshold, phy_termination_trim;
  int fail_count = 0, comparisons = 0, cycles = 0;
  wire [31:0] phy0 = {6'h00, phy_deemph_mid_level, phy_deemph_high_level,
                      phy_amp_full_swing, phy_amp_low_swing};
  wire [31:0] phy1 = {19'h0, phy_signal_loss_threshold,
                      phy_termination_trim, pll_spread_range, pll_spread_on};
  ecl_loader uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .ee_rd_req, .ee_rd_addr, .ee_rd_ack, .ee_rd_data, .usb3_mode,
    .cfg_done, .cfg_present, .poll_fs, .poll_hs, .poll_ss, .bulk_burst,
    .max_power, .phy_deemph_mid_level, .phy_deemph_high_level,
    .phy_amp_full_swing, .phy_amp_low_swing, .phy_signal_loss_threshold,
    .phy_termination_trim, .pll_spread_range, .pll_spread_on);
  ecl_eeprom_model mem_u (.aclk, .ee_rd_req, .ee_rd_addr,
    .wait_cycles(wcyc), .ee_rd_ack, .ee_rd_data);
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_bresp});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    chk("rdata", e, s_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_rresp});
    @(posedge aclk); // Let rready settle low before the next read
  endtask : rd
  task test_absent;
    @(posedge aclk iff cfg_done === 1'b1);
    @(posedge aclk);
    chk("present", 32'h0, {31'h0, cfg_present});
    chk("usb", 32'h0706_0401, {bulk_burst, poll_ss, poll_hs, poll_fs});
    chk("phy0", {6'h0, 6'h16, 6'h20, 7'h69, 7'h35}, phy0);
    chk("phy1", {19'h0, 5'h09, 5'h00, 2'h2, 1'b1}, phy1);
    chk("pwr2", 32'h0000_00FA, {24'h0, max_power});
    usb3_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("pwr3", 32'h0000_0070, {24'h0, max_power});
    rd(8'h0C, 32'h1620_6935, 2'b00);
    rd(8'h14, 32'h0000_0005, 2'b00);
    rd(8'h08, 32'h0000_0008, 2'b00);
    rd(8'h04, 32'h0000_0001, 2'b00);
  endtask : test_absent
  task test_bus;
    wr(8'h18, 32'hFFFF_FFFF, 2'b10);
    rd(8'h18, 32'h1620_6935, 2'b00);
    rd(8'h3C, 32'h0000_0000, 2'b10);
  endtask : test_bus
  task test_present;
    mem_u.mem[0] = 8'hA5;
    {mem_u.mem[11], mem_u.mem[10], mem_u.mem[9], mem_u.mem[8]} = 32'hEAD5_B39A;
    {mem_u.mem[15], mem_u.mem[14], mem_u.mem[13], mem_u.mem[12]} = 32'hFFFF_F4EB;
    {mem_u.mem[19], mem_u.mem[18], mem_u.mem[17], mem_u.mem[16]} = 32'hFFFF_FFFA;
    {mem_u.mem[25], mem_u.mem[24], mem_u.mem[23], mem_u.mem[22],
     mem_u.mem[21], mem_u.mem[20]} = 48'h6655_4433_2211;
    wcyc <= 4'h3;
    wr(8'h00, 32'h0000_0001, 2'b00);
    @(posedge aclk iff ee_rd_addr === 8'h19);
    @(posedge aclk iff cfg_done === 1'b1);
    @(posedge aclk);
    chk("present", 32'h1, {31'h0, cfg_present});
    chk("phy0", {6'h0, 6'h2A, 6'h15, 7'h33, 7'h1A}, phy0);
    chk("phy1", {19'h0, 5'h14, 5'h0B, 2'h1, 1'b0}, phy1);
    chk("usb", 32'h4433_2211, {bulk_burst, poll_ss, poll_hs, poll_fs});
    rd(8'h18, 32'h2A15_331A, 2'b00);
    rd(8'h04, 32'h0000_0003, 2'b00);
    rd(8'h28, 32'h0066_5566, 2'b00);
  endtask : test_present
  initial begin
    mem_u.mem[0] = 8'h5A;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    test_absent();
    test_bus();
    test_present();
    report_and_stop();
  end
endmodule : ecl_loader_test
